// File: verilog/scm_serial_ch.sv
// serial channel: mode select, pin ownership, engines, receive status
`timescale 1ns/1ps
module scm_serial_ch #(
    parameter int BAUD_W = scm_pkg::SCM_BAUD_W
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire scm_pkg::scm_ctrl_t  ctrl,
    input  wire logic [BAUD_W-1:0]   baud_divisor,
    input  wire scm_pkg::scm_port_t  port,
    input  wire logic                pin0_in,
    input  wire logic                pin2_in,
    output logic                     pin0_out,
    output logic                     pin0_oe,
    output logic                     pin1_out,
    output logic                     pin1_oe,
    output logic                     pin2_out,
    output logic                     pin2_oe,
    input  wire logic [7:0]          tx_data,
    input  wire logic                tx_write,
    output logic                     tx_busy,
    output logic [7:0]               rx_data,
    output logic                     rx_valid,
    input  wire logic                rx_ready,
    output scm_pkg::scm_err_t        async_error_status,
    input  wire logic                status_read
);
    typedef enum {rx_idle, rx_start, rx_bits, rx_par, rx_stop} scm_rx_t;

    function automatic scm_pkg::scm_mode_t decode(scm_pkg::scm_ctrl_t c);
        if (!c.tx_enable && !c.rx_enable && !c.clocked_serial_enable)
            return scm_pkg::mode_stop;
        if (c.clocked_serial_enable && !c.tx_enable && !c.rx_enable &&
            !c.baud_clock_select)
            return scm_pkg::mode_three;
        if (!c.clocked_serial_enable && !c.bit_order_select &&
            !c.shift_clock_source)
            return scm_pkg::mode_async;
        // prohibited settings park the channel
        return scm_pkg::mode_stop;
    endfunction

    scm_pkg::scm_mode_t mode_q;
    scm_rx_t            rx_st_q;
    logic [1:0]  rxd_s_q, sck_s_q;
    logic        sck_d1_q, rxd, ext_rise, ext_fall, uart_tick;
    logic [BAUD_W-1:0] bcnt_q;
    logic        tick_q;
    logic [3:0]  ros_q, tos_q, tcnt_q, swcnt_q;
    logic [2:0]  rbit_q;
    logic [7:0]  rsh_q, swsh_q;
    logic        rpar_q, r_done_q, r_frm_q, r_perr_q;
    logic [11:0] tsh_q;
    logic        sck_int_q, sw_rise, sw_done_q, so_bit, so_q;
    logic        lost_q, in_valid, fifo_in_ready, lost_evt;
    logic [2:0]  err_set;

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            rxd_s_q  <= 2'b11;
            sck_s_q  <= 2'b11;
            sck_d1_q <= 1'b1;
        end else begin
            rxd_s_q  <= {rxd_s_q[0], pin0_in};
            sck_s_q  <= {sck_s_q[0], pin2_in};
            sck_d1_q <= sck_s_q[1];
        end
    end
    assign rxd      = rxd_s_q[1];
    assign ext_rise = sck_s_q[1] && !sck_d1_q;
    assign ext_fall = !sck_s_q[1] && sck_d1_q;

    // R1 R2 mode decode
    always_ff @(posedge clk) begin
        if (rst) mode_q <= scm_pkg::mode_stop;
        else     mode_q <= decode(ctrl);
    end

    // stopped channel freezes the generator to save power
    always_ff @(posedge clk) begin
        if (rst || mode_q == scm_pkg::mode_stop) begin
            bcnt_q <= '0;
            tick_q <= 1'b0;
        end else if (bcnt_q == '0) begin
            bcnt_q <= baud_divisor;
            tick_q <= 1'b1;
        end else begin
            bcnt_q <= bcnt_q - 1'b1;
            tick_q <= 1'b0;
        end
    end
    // R5 baud source select
    assign uart_tick = ctrl.baud_clock_select ? tick_q : ext_rise;

    //////////////////////////////////////////////////////////////////////////
    // R8 R15 async receiver, 16 ticks per bit
    always_ff @(posedge clk) begin
        if (rst || mode_q != scm_pkg::mode_async || !ctrl.rx_enable) begin
            rx_st_q  <= rx_idle;
            ros_q    <= '0;
            rbit_q   <= '0;
            rsh_q    <= scm_pkg::SCM_RXB_RESET;
            rpar_q   <= 1'b0;
            r_done_q <= 1'b0;
            r_frm_q  <= 1'b0;
            r_perr_q <= 1'b0;
        end else begin
            r_done_q <= 1'b0;
            if (uart_tick) begin
                ros_q <= ros_q + 4'h1;
                case (rx_st_q)
                    rx_idle: if (!rxd) begin
                        rx_st_q <= rx_start;
                        ros_q   <= '0;
                    end
                    // half-bit recheck rejects glitches on the line
                    rx_start: if (ros_q == scm_pkg::SCM_OS_MID) begin
                        ros_q   <= '0;
                        rbit_q  <= '0;
                        rx_st_q <= rxd ? rx_idle : rx_bits;
                    end
                    rx_bits: if (ros_q == scm_pkg::SCM_OS_LAST) begin
                        rsh_q  <= {rxd, rsh_q[7:1]};
                        rbit_q <= rbit_q + 3'h1;
                        if (rbit_q == scm_pkg::SCM_LAST_BIT)
                            rx_st_q <= (ctrl.parity_mode ==
                                        scm_pkg::SCM_PAR_NONE) ?
                                       rx_stop : rx_par;
                    end
                    rx_par: if (ros_q == scm_pkg::SCM_OS_LAST) begin
                        rpar_q  <= rxd;
                        rx_st_q <= rx_stop;
                    end
                    // R13 one stop bit
                    rx_stop: if (ros_q == scm_pkg::SCM_OS_LAST) begin
                        rx_st_q  <= rx_idle;
                        r_done_q <= 1'b1;
                        r_frm_q  <= !rxd;
                        r_perr_q <= ctrl.parity_mode[1] &&
                                    ((^{rsh_q, rpar_q}) == ctrl.parity_mode[0]);
                    end
                    default: rx_st_q <= rx_idle;
                endcase
            end
        end
    end

    // R4 async transmitter, LSB first
    always_ff @(posedge clk) begin
        if (rst || mode_q != scm_pkg::mode_async || !ctrl.tx_enable) begin
            tsh_q  <= '1;
            tcnt_q <= '0;
            tos_q  <= '0;
        end else if (tcnt_q == '0) begin
            if (tx_write) begin
                tos_q  <= '0;
                tcnt_q <= scm_pkg::SCM_FRAME_BASE +
                          {3'h0, ctrl.stop_length_select} +
                          {3'h0, ctrl.parity_mode != scm_pkg::SCM_PAR_NONE};
                if (ctrl.parity_mode == scm_pkg::SCM_PAR_NONE)
                    tsh_q <= {3'b111, tx_data, 1'b0};
                else if (ctrl.parity_mode == scm_pkg::SCM_PAR_ZERO)
                    tsh_q <= {2'b11, 1'b0, tx_data, 1'b0};
                else
                    tsh_q <= {2'b11, (^tx_data) ^ !ctrl.parity_mode[0],
                              tx_data, 1'b0};
            end
        end else if (uart_tick) begin
            tos_q <= tos_q + 4'h1;
            if (tos_q == scm_pkg::SCM_OS_LAST) begin
                tsh_q  <= {1'b1, tsh_q[11:1]};
                tcnt_q <= tcnt_q - 4'h1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // R2 R3 3-wire shifter: samples on rising, out moves a clock later
    assign sw_rise = ctrl.shift_clock_source ?
                     (tick_q && !sck_int_q && swcnt_q != '0) : ext_rise;
    assign so_bit  = ctrl.bit_order_select ? swsh_q[0] : swsh_q[7];

    always_ff @(posedge clk) begin
        if (rst || mode_q != scm_pkg::mode_three) begin
            swsh_q    <= scm_pkg::SCM_RXB_RESET;
            swcnt_q   <= '0;
            sck_int_q <= 1'b1;
            sw_done_q <= 1'b0;
            so_q      <= 1'b1;
        end else begin
            sw_done_q <= 1'b0;
            // lag keeps data-out from moving with the rising clock pin
            so_q      <= so_bit;
            if (swcnt_q == '0) begin
                sck_int_q <= 1'b1;
                if (tx_write) begin
                    swsh_q  <= tx_data;
                    swcnt_q <= scm_pkg::SCM_SW_BITS;
                end
            end else begin
                if (ctrl.shift_clock_source && tick_q)
                    sck_int_q <= !sck_int_q;
                if (sw_rise) begin
                    swsh_q    <= ctrl.bit_order_select ?
                                 {rxd, swsh_q[7:1]} : {swsh_q[6:0], rxd};
                    swcnt_q   <= swcnt_q - 4'h1;
                    sw_done_q <= (swcnt_q == 4'h1);
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // R1 R3 R4 R5 R6 pin ownership
    always_ff @(posedge clk) begin
        if (rst) begin
            pin0_out <= 1'b0;
            pin0_oe  <= 1'b0;
            pin1_out <= 1'b0;
            pin1_oe  <= 1'b0;
            pin2_out <= 1'b0;
            pin2_oe  <= 1'b0;
            tx_busy  <= 1'b0;
        end else begin
            // R6 data-in pin keeps port drive
            pin0_out <= port.latch[0];
            pin0_oe  <= !port.dir[0];
            tx_busy  <= (tcnt_q != '0) || (swcnt_q != '0);
            if (mode_q == scm_pkg::mode_three) begin
                pin1_out <= so_q;
                pin1_oe  <= 1'b1;
            end else if (mode_q == scm_pkg::mode_async && ctrl.tx_enable) begin
                pin1_out <= tsh_q[0];
                pin1_oe  <= 1'b1;
            end else begin
                pin1_out <= port.latch[1];
                pin1_oe  <= !port.dir[1];
            end
            if (mode_q == scm_pkg::mode_three && ctrl.shift_clock_source) begin
                pin2_out <= sck_int_q;
                pin2_oe  <= 1'b1;
            end else if (mode_q == scm_pkg::mode_three ||
                         (mode_q == scm_pkg::mode_async &&
                          !ctrl.baud_clock_select)) begin
                pin2_out <= 1'b0;
                pin2_oe  <= 1'b0;
            end else begin
                pin2_out <= port.latch[2];
                pin2_oe  <= !port.dir[2];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign in_valid = r_done_q || sw_done_q;
    // R11 R16 overrun while buffer full or unread after a loss
    assign lost_evt = in_valid && (lost_q || !fifo_in_ready);

    scm_fifo #(
        .WIDTH (scm_pkg::SCM_DATA_BITS),
        .DEPTH (scm_pkg::SCM_FIFO_DEPTH)
    ) u_rx_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (in_valid && !lost_evt),
        .in_ready  (fifo_in_ready),
        .in_data   (sw_done_q ? swsh_q : rsh_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // R11 a buffer read clears the loss, a new loss wins
    always_ff @(posedge clk) begin
        if (rst)           lost_q <= 1'b0;
        else if (lost_evt) lost_q <= 1'b1;
        else if (rx_valid && rx_ready) lost_q <= 1'b0;
    end

    // R10 flags carry no meaning in 3-wire mode
    // R9 R14 three flags, set wins over clear-on-read
    assign err_set = {lost_evt, r_done_q && r_frm_q, r_done_q && r_perr_q};
    always_ff @(posedge clk) begin
        if (rst)
            async_error_status <= scm_pkg::SCM_ERR_RESET;
        else
            async_error_status <= (status_read ? scm_pkg::SCM_ERR_RESET :
                                   async_error_status) | err_set;
    end

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_stop_bit;
        rx_st_q == rx_stop && uart_tick && ros_q == scm_pkg::SCM_OS_LAST &&
        mode_q == scm_pkg::mode_async && ctrl.rx_enable;
    endsequence
    sequence s_three_load;
        mode_q == scm_pkg::mode_three && swcnt_q == '0 && tx_write &&
        !ctrl.bit_order_select;
    endsequence

    property p_stop_pins;
        mode_q == scm_pkg::mode_stop |=>
            pin1_oe == !$past(port.dir[1]) && pin2_oe == !$past(port.dir[2]);
    endproperty
    a_stop_pins: assert property (p_stop_pins) // R1
        else $error("stopped channel drives a pin");
    property p_three_decode;
        ctrl.clocked_serial_enable && !ctrl.tx_enable && !ctrl.rx_enable &&
        !ctrl.baud_clock_select |=> mode_q == scm_pkg::mode_three;
    endproperty
    a_three_decode: assert property (p_three_decode) // R2
        else $error("3-wire setting not decoded");
    property p_msb_first;
        s_three_load |=> ##2 pin1_out == $past(tx_data[7], 3);
    endproperty
    a_msb_first: assert property (p_msb_first) // R2
        else $error("first bit is not the msb");
    property p_sck_drive;
        mode_q == scm_pkg::mode_three && ctrl.shift_clock_source |=>
            pin2_oe && pin1_oe;
    endproperty
    a_sck_drive: assert property (p_sck_drive) // R3
        else $error("internal shift clock not driven");
    property p_txd_drive;
        mode_q == scm_pkg::mode_async && ctrl.tx_enable |=> pin1_oe;
    endproperty
    a_txd_drive: assert property (p_txd_drive) // R4
        else $error("async transmit pin not driven");
    property p_baud_pin;
        mode_q == scm_pkg::mode_async && ctrl.baud_clock_select |=>
            pin2_oe == !$past(port.dir[2]);
    endproperty
    a_baud_pin: assert property (p_baud_pin) // R5
        else $error("baud pin not released to port");
    property p_si_port;
        1'b1 |=> pin0_oe == !$past(port.dir[0]);
    endproperty
    a_si_port: assert property (p_si_port) // R6
        else $error("data-in pin not under port control");
    property p_frame_err;
        s_stop_bit ##0 !rxd |=> ##1 async_error_status.framing_error_flag;
    endproperty
    a_frame_err: assert property (p_frame_err) // R8
        else $error("framing error not recorded");
    property p_err_reset;
        disable iff (1'b0) rst |=> async_error_status == scm_pkg::SCM_ERR_RESET;
    endproperty
    a_err_reset: assert property (p_err_reset) // R9
        else $error("status not zero after reset");
    property p_lost_repeat;
        lost_q && in_valid |=> async_error_status.data_lost_flag;
    endproperty
    a_lost_repeat: assert property (p_lost_repeat) // R11
        else $error("overrun not repeated");
    property p_one_stop;
        s_stop_bit |=> rx_st_q == rx_idle;
    endproperty
    a_one_stop: assert property (p_one_stop) // R13
        else $error("receiver waited for a second stop bit");
    property p_overrun;
        in_valid && !fifo_in_ready |=> lost_q && async_error_status[2];
    endproperty
    a_overrun: assert property (p_overrun) // R16
        else $error("overrun missed on full buffer");
endmodule // scm_serial_ch

// File: verilog/scm_pkg.sv
// shared types and constants of the serial channel mode and status block
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - all enables clear: stopped, pins are ports
// R2 - 3-wire mode decode; order bit picks MSB/LSB
// R3 - 3-wire clock source: pin input or driven
// R4 - async tx drives data-out, rx uses data-in
// R5 - async baud from pin or internal generator
// R6 - data-in pin stays a general port pin
// R7 - software programs only the listed combinations
// R8 - async receive errors recorded by type
// R9 - error status read-only, resets to zero
// R10 - error status meaningless in 3-wire mode
// R11 - overrun repeats until buffer is read
// R12 - software reads buffer to clear overrun
// R13 - receiver checks one stop bit only
// R14 - parity, framing, overrun kept as flags
// R15 - completed character moves into receive buffer
// R16 - overrun when buffer unread at completion; code flags it only when the 32-word fifo and output word are full
// R17 - software stops link before mode change
//////////////////////////////////////////////////////////////////////////////
package scm_pkg;

    typedef enum logic [1:0] {mode_stop, mode_three, mode_async} scm_mode_t;

    typedef struct packed {
        logic       tx_enable;
        logic       rx_enable;
        logic       baud_clock_select;
        logic       clocked_serial_enable;
        logic       bit_order_select;
        logic       shift_clock_source;
        logic       stop_length_select;
        logic [1:0] parity_mode;
    } scm_ctrl_t;

    typedef struct packed {
        logic [2:0] dir;
        logic [2:0] latch;
    } scm_port_t;

    typedef struct packed {
        logic data_lost_flag;
        logic framing_error_flag;
        logic parity_error_flag;
    } scm_err_t;

    localparam int         SCM_DATA_BITS  = 8;
    localparam int         SCM_FIFO_DEPTH = 32;
    localparam int         SCM_BAUD_W     = 12;
    localparam logic [3:0] SCM_OS_MID     = 4'h7;
    localparam logic [3:0] SCM_OS_LAST    = 4'hF;
    localparam logic [2:0] SCM_LAST_BIT   = 3'h7;
    localparam logic [3:0] SCM_SW_BITS    = 4'h8;
    localparam logic [3:0] SCM_FRAME_BASE = 4'hA;
    localparam logic [1:0] SCM_PAR_NONE   = 2'h0;
    localparam logic [1:0] SCM_PAR_ZERO   = 2'h1;
    localparam logic [1:0] SCM_PAR_ODD    = 2'h2;
    localparam logic [2:0] SCM_ERR_RESET  = 3'h0;
    localparam logic [7:0] SCM_RXB_RESET  = 8'hFF;

endpackage

// File: verilog/scm_fifo.sv
// receive buffer fifo with registered read data
`timescale 1ns/1ps
module scm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // depth must be a power of two: pointers carry one wrap bit
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    logic             empty;

    assign empty    = (wp_q == rp_q);
    assign in_ready = !((wp_q[AW] != rp_q[AW]) &&
                        (wp_q[AW-1:0] == rp_q[AW-1:0]));

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
        end else if (in_valid && in_ready) begin
            wp_q <= wp_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rp_q      <= '0;
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b1}};
        end else if (!empty && (!out_valid || out_ready)) begin
            out_data  <= mem_q[rp_q[AW-1:0]];
            rp_q      <= rp_q + 1'b1;
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule // scm_fifo

// File: sim/scm_remote.sv
// far-side serial device: async frames and 3-wire transfers
`timescale 1ns/1ps
module scm_remote (
    input  wire logic txd,
    input  wire logic sck,
    input  wire logic sync_mode,
    output logic      rxd,
    output logic      ext_clk
);
    // one bit is 16 ticks of 2 clocks at the bench divisor
    localparam int BIT_NS = 640;
    logic [7:0] got, sgot, sout;
    int         nsck;
    logic       lsb_first;

    initial begin
        rxd = 1'b1;
        ext_clk = 1'b0;
        nsck = 0;
        lsb_first = 1'b0;
    end
    ////////////////////////////////
    // async frames lsb first, 3-wire order from lsb_first
    always @(negedge txd) begin
        if (!sync_mode) begin
            #(BIT_NS * 3 / 2);
            for (int i = 0; i < 8; i++) begin
                got[i] = txd;
                #(BIT_NS);
            end
        end
    end
    always @(negedge sck) begin
        if (sync_mode)
            rxd = lsb_first ? sout[nsck] : sout[7 - nsck];
    end
    always @(posedge sck) begin
        if (sync_mode) begin
            sgot = lsb_first ? {txd, sgot[7:1]} : {sgot[6:0], txd};
            nsck = nsck + 1;
        end
    end
    ////////////////////////////////
    // external clock runs only while a bit is on the line
    task automatic put(input logic v, input bit ext);
        rxd = v;
        if (ext) begin
            repeat (16) begin
                #80 ext_clk = 1'b1;
                #80 ext_clk = 1'b0;
            end
        end
        else
            #(BIT_NS);
    endtask
    // one stop bit, frames back to back
    task automatic send(input logic [7:0] b, input logic [1:0] pb,
                        input logic stop, input bit ext);
        #7;
        put(1'b0, ext);
        for (int i = 0; i < 8; i++)
            put(b[i], ext);
        if (pb[1])
            put(pb[0], ext);
        put(stop, ext);
    endtask
endmodule // scm_remote

// File: sim/scm_serial_ch_tb.sv
// self-checking bench for the serial channel block
`timescale 1ns/1ps
module scm_serial_ch_tb;
    logic               clk, rst, tx_write, rx_ready, status_read;
    scm_pkg::scm_ctrl_t ctrl;
    scm_pkg::scm_port_t port;
    scm_pkg::scm_err_t  async_error_status;
    logic [11:0]        baud_divisor;
    logic [7:0]         tx_data, rx_data;
    logic               pin0_in, pin2_in, pin0_out, pin0_oe, pin1_out;
    logic               pin1_oe, pin2_out, pin2_oe, tx_busy, rx_valid;
    logic               rxd, ext_clk, sync_mode;
    int                 num_errors, samples_checked;
    wire logic [2:0]    oes = {pin2_oe, pin1_oe, pin0_oe};

    // the channel wins the wire where it drives
    assign pin0_in = pin0_oe ? pin0_out : rxd;
    assign pin2_in = pin2_oe ? pin2_out : ext_clk;

    scm_serial_ch u_scm_serial_ch (
        .clk(clk), .rst(rst), .ctrl(ctrl), .baud_divisor(baud_divisor),
        .port(port), .pin0_in(pin0_in), .pin2_in(pin2_in),
        .pin0_out(pin0_out), .pin0_oe(pin0_oe), .pin1_out(pin1_out),
        .pin1_oe(pin1_oe), .pin2_out(pin2_out), .pin2_oe(pin2_oe),
        .tx_data(tx_data), .tx_write(tx_write), .tx_busy(tx_busy),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .async_error_status(async_error_status),
        .status_read(status_read));
    // an undriven data-out line rests high on its pull-up
    scm_remote u_scm_remote (.txd(pin1_oe ? pin1_out : 1'b1), .sck(pin2_in),
        .sync_mode(sync_mode), .rxd(rxd), .ext_clk(ext_clk));

    always #10 clk = ~clk;
    ////////////////////////////////
    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stat(input logic [2:0] e);
        @(negedge clk);
        check({5'h00, async_error_status}, {5'h00, e});
    endtask
    task automatic wait_on(input bit rxv, input int n);
        int k;
        k = 0;
        while ((rxv ? rx_valid !== 1'b1 : tx_busy !== 1'b0) && k < n) begin
            @(negedge clk);
            k++;
        end
        if (k >= n) begin
            num_errors++;
            $display("BAD %0t wait ran out", $time);
            conclude();
        end
    endtask
    task automatic do_reset(input int n);
        @(negedge clk);
        rst = 1'b1;
        repeat (n) @(negedge clk);
        check({oes, rx_valid, 4'h0}, 8'h00);
        check(rx_data, 8'hFF);
        stat(3'h0);
        rst = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // stop the link before any change of mode
    task automatic set_mode(input logic [8:0] c);
        @(negedge clk);
        ctrl = '0;
        repeat (3) @(negedge clk);
        ctrl = scm_pkg::scm_ctrl_t'(c);
        repeat (3) @(negedge clk);
    endtask
    task automatic send_tx(input logic [7:0] b);
        @(negedge clk);
        tx_data = b;
        tx_write = 1'b1;
        @(negedge clk);
        tx_write = 1'b0;
        repeat (2) @(negedge clk);
        wait_on(1'b0, 20000);
    endtask
    task automatic pop(input logic [7:0] e);
        @(negedge clk);
        wait_on(1'b1, 4000);
        check(rx_data, e);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask
    task automatic clear_status();
        @(negedge clk);
        status_read = 1'b1;
        @(negedge clk);
        status_read = 1'b0;
    endtask
    ////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ctrl = '0;
        port = 6'h1D;
        baud_divisor = 12'h001;
        tx_data = 8'h00;
        tx_write = 1'b0;
        rx_ready = 1'b0;
        status_read = 1'b0;
        sync_mode = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        do_reset(8);
        check({4'h0, oes, pin2_out}, 8'h09);
        set_mode(9'h140);
        check({5'h00, oes}, 8'h06);
        send_tx(8'hA5);
        check(u_scm_remote.got, 8'hA5);
        set_mode(9'h100);
        check({5'h00, oes}, 8'h02);
        set_mode(9'h0C6);
        check({5'h00, oes}, 8'h04);
        u_scm_remote.send(8'h3C, 2'h3, 1'b1, 1'b0);
        u_scm_remote.send(8'h81, 2'h3, 1'b1, 1'b0);
        pop(8'h3C);
        pop(8'h81);
        stat(3'h0);
        u_scm_remote.send(8'h3C, 2'h2, 1'b1, 1'b0);
        pop(8'h3C);
        stat(3'h1);
        clear_status();
        stat(3'h0);
        u_scm_remote.send(8'h55, 2'h3, 1'b0, 1'b0);
        u_scm_remote.put(1'b1, 1'b0);
        stat(3'h2);
        do_reset(1);
        set_mode(9'h080);
        check({5'h00, oes}, 8'h00);
        u_scm_remote.send(8'hC3, 2'h0, 1'b1, 1'b1);
        pop(8'hC3);
        set_mode(9'h0C0);
        // buffer holds its 32 words plus the registered output word
        for (int i = 0; i < 34; i++) begin
            u_scm_remote.send(i[7:0], 2'h0, 1'b1, 1'b0);
            if (i == 32)
                stat(3'h0);
        end
        stat(3'h4);
        clear_status();
        stat(3'h0);
        u_scm_remote.send(8'hEE, 2'h0, 1'b1, 1'b0);
        stat(3'h4);
        pop(8'h00);
        clear_status();
        u_scm_remote.send(8'h77, 2'h0, 1'b1, 1'b0);
        stat(3'h0);
        // status is left unread in 3-wire mode
        do_reset(1);
        baud_divisor = 12'h00F;
        sync_mode = 1'b1;
        port = 6'h15;
        set_mode(9'h028);
        check({4'h0, oes, pin0_out}, 8'h0F);
        port = 6'h1D;
        for (int o = 0; o < 2; o++) begin
            set_mode(o ? 9'h038 : 9'h028);
            u_scm_remote.lsb_first = o[0];
            u_scm_remote.nsck = 0;
            u_scm_remote.sout = 8'h96;
            send_tx(8'h12);
            check(u_scm_remote.sgot, 8'h12);
            pop(8'h96);
        end
        set_mode(9'h020);
        check({5'h00, oes}, 8'h02);
        conclude();
    end
endmodule // scm_serial_ch_tb
